// ==== hdl/cor_opregs.sv ====
`timescale 1ns/1ps
`include "cor_regs.svh"

// What this block does
// R01 - Twelve-bit counter addresses 4K program words
// R02 - Jump loads low ten counter bits
// R03 - Call pushes counter plus one, loads bits
// R04 - Return reloads counter from stack top; same-cycle counter write wins
// R05 - Returns leave page select bits alone
// R06 - Counter write loads byte, keeps bits eight, nine
// R07 - Accumulator add offsets current counter
// R08 - Counter writes copy page into top bits
// R09 - Timeout flag set by sleep, clear, power-up
// R10 - Power-down flag set power-on, clear; sleep clears
// R11 - Flag pairs follow wake and reset causes
// R12 - Pointer top bits pick data bank
// R13 - Pointer low bits give indirect address
// R14 - Port five bit zero picks control page
// R15 - Port data registers, direction from control
// R16 - Display bit seven selects bias
// R17 - Bits six, five select display duty
// R18 - Display disabled drives outputs to ground
// R19 - Bit two selects drive waveform type
// R20 - Frame rate divides sub-oscillator per common
// R21 - Display pointer five bits, top reads zero
// R22 - Counter run bits start and stop timers
// R23 - Address zero redirects through RAM pointer
// R24 - Display window moves nibble at pointer
// R25 - Unused bits read zero, ignore writes
module cor_opregs
    import cor_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic [5:0]  reg_addr,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [7:0]  reg_wdata,
    output logic [7:0]       reg_rdata,
    output logic [7:0]       ext_addr,
    output logic             ext_wr,
    output logic             ext_rd,
    output logic [7:0]       ext_wdata,
    input  wire logic [7:0]  ext_rdata,
    input  wire cor_pc_op_t  pc_op,
    input  wire logic [9:0]  pc_target,
    input  wire logic [7:0]  acc,
    input  wire logic [11:0] stack_top,
    output logic [11:0]      pc_addr,
    output logic             push_valid,
    output logic [11:0]      push_data,
    input  wire logic        alu_flags_we,
    input  wire logic [2:0]  alu_flags,
    input  wire logic        sleep_exec,
    input  wire logic        watchdog_clear_instruction_exec,
    input  wire logic        wdt_timeout,
    input  wire logic        reset_pin_event,
    output logic [1:0]       data_bank,
    output logic             control_page_select,
    input  wire logic [3:0]  p5_dir,
    input  wire logic [3:0]  p5_pin,
    output logic [3:0]       p5_out,
    input  wire logic [7:0]  p6_dir,
    input  wire logic [7:0]  p6_pin,
    output logic [7:0]       p6_out,
    input  wire logic [7:0]  p7_dir,
    input  wire logic [7:0]  p7_pin,
    output logic [7:0]       p7_out,
    input  wire logic [7:0]  p8_dir,
    input  wire logic [7:0]  p8_pin,
    output logic [7:0]       p8_out,
    output logic [3:0]       counter_run,
    input  wire logic        sub_osc_tick,
    output logic             bias_select,
    output logic             waveform_type_select,
    output logic             disp_com_tick,
    output logic [1:0]       disp_com_idx,
    output logic [31:0]      disp_seg
);

    logic [11:0] pc_r;
    logic [7:0]  status_r;
    logic [7:0]  ram_ptr_r;
    logic [7:0]  port5_r;
    logic [7:0]  port6_r;
    logic [7:0]  port7_r;
    logic [7:0]  port8_r;
    logic [7:0]  disp_ctrl_r;
    logic [7:0]  disp_ptr_r;
    logic [7:0]  cnt_run_r;
    logic        asleep_r;
    logic [5:0]  eff_addr;
    logic        own_reg;
    logic        wr_hit;
    logic [7:0]  rd_nxt;
    logic [1:0]  page;
    logic [11:0] pc_sum;

    cor_disp_if dif ();

    // ---------------------------------------------------------------
    // Address redirection and decode
    // ---------------------------------------------------------------
    assign eff_addr = (reg_addr == `COR_OFS_INDIRECT) ? ram_ptr_r[5:0] : reg_addr; // R23
    assign own_reg  = (eff_addr >= `COR_OFS_PC_LOW) && (eff_addr <= `COR_OFS_CNT_RUN);
    assign wr_hit   = clk_en && reg_wr;
    assign ext_addr = {ram_ptr_r[7:`COR_PTR_BANK_LSB], eff_addr}; // R12
    assign ext_wr   = wr_hit && !own_reg && (eff_addr != `COR_OFS_INDIRECT);
    assign ext_rd   = clk_en && reg_rd && !own_reg && (eff_addr != `COR_OFS_INDIRECT);
    assign ext_wdata = reg_wdata;
    assign page     = status_r[`COR_STAT_PAGE_LSB +: 2];
    assign pc_sum   = pc_r + {4'h0, acc};

    assign pc_addr             = pc_r; // R01
    assign data_bank           = ram_ptr_r[7:`COR_PTR_BANK_LSB]; // R12
    assign control_page_select = port5_r[`COR_P5_PAGE]; // R14
    assign p5_out              = port5_r[7:`COR_P5_DATA_LSB]; // R15
    assign p6_out              = port6_r;
    assign p7_out              = port7_r;
    assign p8_out              = port8_r;
    assign counter_run         = cnt_run_r[3:0]; // R22
    assign bias_select          = disp_ctrl_r[`COR_DC_BIAS]; // R16
    assign waveform_type_select = disp_ctrl_r[`COR_DC_TYPE]; // R19

    assign dif.enable = disp_ctrl_r[`COR_DC_ENABLE];
    assign dif.duty   = disp_ctrl_r[`COR_DC_DUTY_LSB +: 2];
    assign dif.rate   = disp_ctrl_r[`COR_DC_FRATE_LSB +: 2];
    assign dif.ptr    = disp_ptr_r[4:0];
    assign dif.wr     = wr_hit && (eff_addr == `COR_OFS_DISP_WIN); // R24
    assign dif.wdata  = reg_wdata[3:0];

    cor_disp u_disp (
        .sys_clk      (sys_clk),
        .reset        (reset),
        .clk_en       (clk_en),
        .sub_osc_tick (sub_osc_tick),
        .dif          (dif.disp),
        .com_tick     (disp_com_tick),
        .com_idx      (disp_com_idx),
        .seg_bits     (disp_seg)
    );

    // ---------------------------------------------------------------
    // Program counter
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            pc_r <= 12'h000;
        end else if (clk_en) begin
            if (reg_wr && eff_addr == `COR_OFS_PC_LOW) begin
                pc_r <= cor_paged(page, {pc_r[9:8], reg_wdata}); // R06 R08
            end else begin
                case (pc_op)
                    COR_PC_INC:  pc_r <= pc_r + 12'h001;
                    COR_PC_JUMP: pc_r <= cor_paged(page, pc_target); // R02 R08
                    COR_PC_CALL: pc_r <= cor_paged(page, pc_target); // R03 R08
                    COR_PC_RET:  pc_r <= stack_top; // R04 R05
                    COR_PC_ADD:  pc_r <= cor_paged(page, pc_sum[9:0]); // R07 R08
                    default:     pc_r <= pc_r;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            push_valid <= 1'b0;
            push_data  <= 12'h000;
        end else if (clk_en) begin
            push_valid <= (pc_op == COR_PC_CALL) && !(reg_wr && eff_addr == `COR_OFS_PC_LOW);
            if (pc_op == COR_PC_CALL) begin
                push_data <= pc_r + 12'h001; // R03
            end
        end
    end

    // ---------------------------------------------------------------
    // Status register and wake cause flags
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            asleep_r <= 1'b0;
        end else if (clk_en) begin
            if (wdt_timeout || reset_pin_event) begin
                asleep_r <= 1'b0;
            end else if (sleep_exec) begin
                asleep_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            status_r <= `COR_STATUS_RST; // R09 R10
        end else if (clk_en) begin
            if (reg_wr && eff_addr == `COR_OFS_STATUS) begin
                status_r[7]   <= 1'b0; // R25
                status_r[6:5] <= reg_wdata[6:5];
                status_r[2:0] <= reg_wdata[2:0];
            end else if (alu_flags_we) begin
                status_r[2:0] <= alu_flags;
            end
            if (reset_pin_event) begin
                status_r[`COR_STAT_TIMEOUT] <= 1'b1; // R11
                status_r[`COR_STAT_PWRDN]   <= !asleep_r; // R11
            end else begin
                if (sleep_exec || watchdog_clear_instruction_exec) begin
                    status_r[`COR_STAT_TIMEOUT] <= 1'b1; // R09
                end else if (wdt_timeout) begin
                    status_r[`COR_STAT_TIMEOUT] <= 1'b0; // R09
                end
                if (sleep_exec) begin
                    status_r[`COR_STAT_PWRDN] <= 1'b0; // R10
                end else if (watchdog_clear_instruction_exec) begin
                    status_r[`COR_STAT_PWRDN] <= 1'b1; // R10
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Pointer, port and control registers
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            ram_ptr_r   <= `COR_GEN_RST;
            port5_r     <= `COR_GEN_RST;
            port6_r     <= `COR_GEN_RST;
            port7_r     <= `COR_GEN_RST;
            port8_r     <= `COR_GEN_RST;
            disp_ctrl_r <= `COR_GEN_RST;
            disp_ptr_r  <= `COR_GEN_RST;
            cnt_run_r   <= `COR_GEN_RST;
        end else if (wr_hit) begin
            case (eff_addr)
                `COR_OFS_RAM_PTR:   ram_ptr_r   <= reg_wdata; // R13
                `COR_OFS_PORT5:     port5_r     <= reg_wdata & `COR_P5_MASK; // R15 R25
                `COR_OFS_PORT6:     port6_r     <= reg_wdata; // R15
                `COR_OFS_PORT7:     port7_r     <= reg_wdata;
                `COR_OFS_PORT8:     port8_r     <= reg_wdata;
                `COR_OFS_DISP_CTRL: disp_ctrl_r <= reg_wdata & `COR_DC_MASK; // R16 R17 R18
                `COR_OFS_DISP_PTR:  disp_ptr_r  <= reg_wdata & `COR_DISP_PTR_MASK; // R21
                `COR_OFS_CNT_RUN:   cnt_run_r   <= reg_wdata & `COR_CNT_RUN_MASK; // R22 R25
                default:            cnt_run_r   <= cnt_run_r;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Read data, one cycle after the read strobe
    // ---------------------------------------------------------------
    always_comb begin
        rd_nxt = 8'h00;
        case (eff_addr)
            `COR_OFS_PC_LOW:    rd_nxt = pc_r[7:0];
            `COR_OFS_STATUS:    rd_nxt = status_r & 8'h7f;
            `COR_OFS_RAM_PTR:   rd_nxt = ram_ptr_r;
            `COR_OFS_PORT5:     rd_nxt = cor_port_rd(port5_r, {p5_dir, 4'h0}, {p5_pin, 4'h0})
                                         | {7'h00, port5_r[`COR_P5_PAGE]};
            `COR_OFS_PORT6:     rd_nxt = cor_port_rd(port6_r, p6_dir, p6_pin); // R15
            `COR_OFS_PORT7:     rd_nxt = cor_port_rd(port7_r, p7_dir, p7_pin);
            `COR_OFS_PORT8:     rd_nxt = cor_port_rd(port8_r, p8_dir, p8_pin);
            `COR_OFS_DISP_CTRL: rd_nxt = disp_ctrl_r;
            `COR_OFS_DISP_PTR:  rd_nxt = disp_ptr_r; // R21
            `COR_OFS_DISP_WIN:  rd_nxt = {4'h0, dif.rdata}; // R24 R25
            `COR_OFS_CNT_RUN:   rd_nxt = cnt_run_r;
            `COR_OFS_INDIRECT:  rd_nxt = 8'h00;
            default:            rd_nxt = ext_rdata; // R23
        endcase
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            reg_rdata <= 8'h00;
        end else if (clk_en && reg_rd) begin
            reg_rdata <= rd_nxt;
        end
    end

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (reset);

    jump_load_a: assert property ( // R02
        clk_en && pc_op == COR_PC_JUMP && !reg_wr |=> pc_r == {$past(page), $past(pc_target)})
        else $error("jump target not loaded");
    call_push_a: assert property ( // R03
        clk_en && pc_op == COR_PC_CALL && !reg_wr
        |=> push_valid && push_data == $past(pc_r) + 12'h001)
        else $error("call did not push next address");
    ret_load_a: assert property ( // R04
        clk_en && pc_op == COR_PC_RET && !reg_wr |=> pc_r == $past(stack_top))
        else $error("return did not reload from stack");
    pc_write_a: assert property ( // R06
        clk_en && reg_wr && eff_addr == `COR_OFS_PC_LOW
        |=> pc_r[9:0] == {$past(pc_r[9:8]), $past(reg_wdata)} && pc_r[11:10] == $past(page))
        else $error("counter write corrupted bits");
    sleep_flags_a: assert property ( // R10
        clk_en && sleep_exec && !wdt_timeout && !reset_pin_event
        |=> status_r[`COR_STAT_TIMEOUT] && !status_r[`COR_STAT_PWRDN] && asleep_r)
        else $error("sleep flags wrong");
    wdt_wake_a: assert property ( // R11
        clk_en && asleep_r && wdt_timeout && !reset_pin_event && !watchdog_clear_instruction_exec && !sleep_exec
        |=> status_r[4:3] == 2'b00)
        else $error("watchdog wake flags wrong");
    pin_wake_a: assert property ( // R11
        clk_en && reset_pin_event && asleep_r |=> status_r[4:3] == 2'b10)
        else $error("pin wake flags wrong");
    indirect_a: assert property ( // R23
        reg_addr == `COR_OFS_INDIRECT |-> ext_addr == ram_ptr_r)
        else $error("indirect address not from pointer");
    unused_zero_a: assert property ( // R25
        disp_ptr_r[7:5] == 3'h0 && cnt_run_r[7:4] == 4'h0 && port5_r[3:1] == 3'h0)
        else $error("unused bits not zero");
    disp_off_a: assert property ( // R18
        clk_en && !dif.enable |=> disp_seg == 32'h0)
        else $error("disabled display drives segments");

    call_cov: cover property (clk_en && pc_op == COR_PC_CALL ##[1:20] pc_op == COR_PC_RET);
    wake_cov: cover property (clk_en && sleep_exec ##[1:20] wdt_timeout);
    tick_cov: cover property (disp_com_tick && disp_com_idx == 2'h3);

endmodule

// ==== hdl/cor_regs.svh ====
`ifndef COR_REGS_SVH
`define COR_REGS_SVH

// ---------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------
`define COR_OFS_INDIRECT    6'h00
`define COR_OFS_PC_LOW      6'h02
`define COR_OFS_STATUS      6'h03
`define COR_OFS_RAM_PTR     6'h04
`define COR_OFS_PORT5       6'h05
`define COR_OFS_PORT6       6'h06
`define COR_OFS_PORT7       6'h07
`define COR_OFS_PORT8       6'h08
`define COR_OFS_DISP_CTRL   6'h09
`define COR_OFS_DISP_PTR    6'h0a
`define COR_OFS_DISP_WIN    6'h0b
`define COR_OFS_CNT_RUN     6'h0c

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define COR_STAT_PAGE_LSB   5
`define COR_STAT_TIMEOUT    4
`define COR_STAT_PWRDN      3
`define COR_PTR_BANK_LSB    6
`define COR_P5_PAGE         0
`define COR_P5_DATA_LSB     4
`define COR_DC_BIAS         7
`define COR_DC_DUTY_LSB     5
`define COR_DC_ENABLE       4
`define COR_DC_TYPE         2
`define COR_DC_FRATE_LSB    0
`define COR_PC_PAGE_LSB     10

// ---------------------------------------------------------------
// Reset values and writable masks
// ---------------------------------------------------------------
`define COR_STATUS_RST      8'h18
`define COR_GEN_RST         8'h00
`define COR_STATUS_WMASK    8'h67
`define COR_P5_MASK         8'hf1
`define COR_DC_MASK         8'hf7
`define COR_DISP_PTR_MASK   8'h1f
`define COR_DISP_WIN_MASK   8'h0f
`define COR_CNT_RUN_MASK    8'h0f

// ---------------------------------------------------------------
// Frame divisors per common, in sub-oscillator ticks
// ---------------------------------------------------------------
`define COR_DIV_D2_0        9'd256
`define COR_DIV_D2_1        9'd280
`define COR_DIV_D2_2        9'd304
`define COR_DIV_D2_3        9'd232
`define COR_DIV_D3_0        9'd172
`define COR_DIV_D3_1        9'd188
`define COR_DIV_D3_2        9'd204
`define COR_DIV_D3_3        9'd156
`define COR_DIV_D4_0        9'd128
`define COR_DIV_D4_1        9'd140
`define COR_DIV_D4_2        9'd152
`define COR_DIV_D4_3        9'd116

`endif

// ==== hdl/cor_pkg.sv ====
`include "cor_regs.svh"

package cor_pkg;

    typedef enum logic [2:0] {
        COR_PC_HOLD = 3'h0,
        COR_PC_INC  = 3'h1,
        COR_PC_JUMP = 3'h2,
        COR_PC_CALL = 3'h3,
        COR_PC_RET  = 3'h4,
        COR_PC_ADD  = 3'h5
    } cor_pc_op_t;

    // Port read: input bits (direction 1) show the pin, output bits the latch.
    function automatic logic [7:0] cor_port_rd(input logic [7:0] latch,
                                               input logic [7:0] dir,
                                               input logic [7:0] pin);
        cor_port_rd = (latch & ~dir) | (pin & dir);
    endfunction

    // Page bits always land in the top two address bits.
    function automatic logic [11:0] cor_paged(input logic [1:0] page,
                                              input logic [9:0] low);
        cor_paged = {page, low};
    endfunction

    // Sub-oscillator ticks per common for a duty and frame rate setting.
    function automatic logic [8:0] cor_frame_div(input logic [1:0] duty,
                                                 input logic [1:0] rate);
        logic [8:0] d;
        d = `COR_DIV_D4_0;
        if (duty[1]) begin
            case (rate)
                2'h0:    d = `COR_DIV_D4_0;
                2'h1:    d = `COR_DIV_D4_1;
                2'h2:    d = `COR_DIV_D4_2;
                default: d = `COR_DIV_D4_3;
            endcase
        end else if (duty[0]) begin
            case (rate)
                2'h0:    d = `COR_DIV_D3_0;
                2'h1:    d = `COR_DIV_D3_1;
                2'h2:    d = `COR_DIV_D3_2;
                default: d = `COR_DIV_D3_3;
            endcase
        end else begin
            case (rate)
                2'h0:    d = `COR_DIV_D2_0;
                2'h1:    d = `COR_DIV_D2_1;
                2'h2:    d = `COR_DIV_D2_2;
                default: d = `COR_DIV_D2_3;
            endcase
        end
        cor_frame_div = d;
    endfunction

endpackage

// ==== hdl/cor_disp_if.sv ====
`timescale 1ns/1ps

interface cor_disp_if;
    logic       enable;
    logic [1:0] duty;
    logic [1:0] rate;
    logic [4:0] ptr;
    logic       wr;
    logic [3:0] wdata;
    logic [3:0] rdata;

    modport core (output enable, output duty, output rate, output ptr,
                  output wr, output wdata, input rdata);
    modport disp (input enable, input duty, input rate, input ptr,
                  input wr, input wdata, output rdata);
endinterface

// ==== hdl/cor_disp.sv ====
`timescale 1ns/1ps

module cor_disp
    import cor_pkg::*;
(
    input  wire logic   sys_clk,
    input  wire logic   reset,
    input  wire logic   clk_en,
    input  wire logic   sub_osc_tick,
    cor_disp_if.disp    dif,
    output logic        com_tick,
    output logic [1:0]  com_idx,
    output logic [31:0] seg_bits
);

    logic [3:0] ram_r [32];
    logic [8:0] div_cnt_r;
    logic [8:0] div_nxt;
    logic [1:0] last_com;

    assign dif.rdata = ram_r[dif.ptr];
    assign div_nxt   = cor_frame_div(dif.duty, dif.rate);
    assign last_com  = dif.duty[1] ? 2'h3 : (dif.duty[0] ? 2'h2 : 2'h1);

    // ---------------------------------------------------------------
    // Display memory, one nibble of commons per segment
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < 32; i++) begin
                ram_r[i] <= 4'h0;
            end
        end else if (clk_en && dif.wr) begin
            ram_r[dif.ptr] <= dif.wdata; // R24
        end
    end

    // ---------------------------------------------------------------
    // Frame divider and common scan
    // ---------------------------------------------------------------
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            div_cnt_r <= 9'h000;
            com_idx   <= 2'h0;
            com_tick  <= 1'b0;
        end else if (clk_en) begin
            com_tick <= 1'b0;
            if (!dif.enable) begin
                div_cnt_r <= 9'h000; // R18
                com_idx   <= 2'h0;
            end else if (sub_osc_tick) begin
                if (div_cnt_r >= div_nxt - 9'h001) begin
                    div_cnt_r <= 9'h000; // R20
                    com_tick  <= 1'b1;
                    com_idx   <= (com_idx >= last_com) ? 2'h0 : com_idx + 2'h1; // R17
                end else begin
                    div_cnt_r <= div_cnt_r + 9'h001;
                end
            end
        end
    end

    // Disabled display holds every segment at ground level.
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            seg_bits <= 32'h0000_0000;
        end else if (clk_en) begin
            for (int i = 0; i < 32; i++) begin
                seg_bits[i] <= dif.enable & ram_r[i][com_idx]; // R18
            end
        end
    end

endmodule

// ==== verif/cor_ext_mem.sv ====
`timescale 1ns/1ps

// Outside data memory: a read is answered in the same cycle; when idle the
// bus shows the inverse of the addressed byte so that stale data never matches.
module cor_ext_mem (
    input  wire logic       sys_clk,
    input  wire logic [7:0] ext_addr,
    input  wire logic       ext_wr,
    input  wire logic       ext_rd,
    input  wire logic [7:0] ext_wdata,
    output logic [7:0]      ext_rdata
);
    logic [7:0] mem_r [256];

    always_ff @(posedge sys_clk) begin
        if (ext_wr) begin
            mem_r[ext_addr] <= ext_wdata;
        end
    end

    assign ext_rdata = ext_rd ? mem_r[ext_addr] : ~mem_r[ext_addr];
endmodule

// ==== verif/core_operational_registers_test.sv ====
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
    $display("Error %s expected %h seen %h", n, e, s); end end

module core_operational_registers_test
    import cor_pkg::*;
;
    logic        sys_clk, reset, reg_wr, reg_rd, push_valid, cps, bias, wtype, ctick;
    logic        ext_wr, ext_rd, ce;
    logic [5:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, ext_addr, ext_wdata, ext_rdata, dir, pin, q;
    logic [4:0]  evt;
    logic [9:0]  pc_target;
    logic [11:0] pc_addr, push_data;
    logic [1:0]  data_bank, cidx;
    logic [3:0]  p5_out, crun;
    logic [7:0]  pout [3];
    logic [31:0] seg;
    cor_pc_op_t  pc_op;
    int          failures, checks, cyc, n;

    cor_opregs dut_u (.sys_clk(sys_clk), .reset(reset), .clk_en(ce), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .ext_addr(ext_addr), .ext_wr(ext_wr), .ext_rd(ext_rd), .ext_wdata(ext_wdata),
        .ext_rdata(ext_rdata), .pc_op(pc_op), .pc_target(pc_target), .acc(8'h10),
        .stack_top(12'habc), .pc_addr(pc_addr), .push_valid(push_valid),
        .push_data(push_data), .alu_flags_we(evt[4]), .alu_flags(3'h5),
        .sleep_exec(evt[0]), .watchdog_clear_instruction_exec(evt[1]), .wdt_timeout(evt[2]),
        .reset_pin_event(evt[3]), .data_bank(data_bank), .control_page_select(cps),
        .p5_dir(dir[3:0]), .p5_pin(pin[7:4]), .p5_out(p5_out), .p6_dir(dir), .p6_pin(pin),
        .p6_out(pout[0]), .p7_dir(dir), .p7_pin(pin), .p7_out(pout[1]), .p8_dir(dir),
        .p8_pin(pin), .p8_out(pout[2]), .counter_run(crun), .sub_osc_tick(1'b1),
        .bias_select(bias), .waveform_type_select(wtype), .disp_com_tick(ctick),
        .disp_com_idx(cidx), .disp_seg(seg));

    cor_ext_mem mem_u (.sys_clk(sys_clk), .ext_addr(ext_addr), .ext_wr(ext_wr),
        .ext_rd(ext_rd), .ext_wdata(ext_wdata), .ext_rdata(ext_rdata));

    initial begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    // ---------------------------------------------------------------
    // Bus and event helpers
    // ---------------------------------------------------------------
    task automatic acc_reg(input logic w, input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= !w;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    task automatic pcop(input cor_pc_op_t op, input logic [9:0] t);
        @(posedge sys_clk);
        pc_op <= op;
        pc_target <= t;
        @(posedge sys_clk);
        pc_op <= COR_PC_HOLD;
        #1;
    endtask

    // Pulses the chosen events for one cycle, then reads back the low status bits.
    task automatic stf(input logic [4:0] m, input logic [7:0] e);
        @(posedge sys_clk);
        evt <= m;
        @(posedge sys_clk);
        evt <= 5'h0;
        acc_reg(1'b0, 6'h03, 8'h00);
        `CHK("status flags", e, q & 8'h1f)
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end

    initial begin
        reset = 1'b1;
        {reg_wr, reg_rd, evt, reg_addr, reg_wdata, pc_target} = '0;
        pc_op = COR_PC_HOLD;
        ce = 1'b1;
        dir = 8'hf0;
        pin = 8'ha5;
        repeat (20) @(posedge sys_clk);
        reset <= 1'b0;
        acc_reg(1'b0, 6'h03, 8'h00);
        `CHK("status reset", 8'h18, q)
        acc_reg(1'b1, 6'h03, 8'h20);
        pcop(COR_PC_JUMP, 10'h155);
        `CHK("pc jump", 12'h555, pc_addr)
        pcop(COR_PC_CALL, 10'h0aa);
        `CHK("pc call", 12'h4aa, pc_addr)
        `CHK("push", 13'h1556, {push_valid, push_data})
        pcop(COR_PC_RET, 10'h0);
        `CHK("pc ret", 12'habc, pc_addr)
        acc_reg(1'b0, 6'h03, 8'h00);
        `CHK("page kept", 8'h20, q & 8'h60)
        pcop(COR_PC_ADD, 10'h0);
        `CHK("pc add", 12'h6cc, pc_addr)
        acc_reg(1'b1, 6'h02, 8'h5a);
        `CHK("pc write", 12'h65a, pc_addr)
        pcop(COR_PC_INC, 10'h0);
        `CHK("pc inc", 12'h65b, pc_addr)
        stf(5'h10, 8'h1d);
        stf(5'h04, 8'h0d);
        stf(5'h01, 8'h15);
        stf(5'h04, 8'h05);
        stf(5'h02, 8'h1d);
        stf(5'h01, 8'h15);
        stf(5'h08, 8'h15);
        stf(5'h08, 8'h1d);
        acc_reg(1'b1, 6'h04, 8'hc5);
        `CHK("bank", 2'h3, data_bank)
        acc_reg(1'b0, 6'h04, 8'h00);
        `CHK("pointer", 8'hc5, q)
        acc_reg(1'b1, 6'h04, 8'h46);
        acc_reg(1'b1, 6'h00, 8'h3c);
        `CHK("indirect own", 8'h3c, pout[0])
        acc_reg(1'b1, 6'h04, 8'h90);
        acc_reg(1'b1, 6'h00, 8'h77);
        acc_reg(1'b0, 6'h00, 8'h00);
        `CHK("indirect ext", 8'h77, q)
        acc_reg(1'b1, 6'h05, 8'hff);
        acc_reg(1'b0, 6'h05, 8'h00);
        `CHK("port5", 13'h1ff1, {cps, p5_out, q})
        for (int i = 0; i < 3; i++) begin
            acc_reg(1'b1, 6'(6 + i), 8'h3c);
            acc_reg(1'b0, 6'(6 + i), 8'h00);
            `CHK("port", 16'hac3c, {q, pout[i]})
        end
        acc_reg(1'b1, 6'h0c, 8'hff);
        acc_reg(1'b0, 6'h0c, 8'h00);
        `CHK("counter run", 12'hf0f, {crun, q})
        @(posedge sys_clk);
        ce <= 1'b0;
        acc_reg(1'b1, 6'h0c, 8'h00);
        @(posedge sys_clk);
        ce <= 1'b1;
        `CHK("frozen", 4'hf, crun)
        acc_reg(1'b1, 6'h09, 8'hff);
        acc_reg(1'b0, 6'h09, 8'h00);
        `CHK("display ctrl", 10'h3f7, {bias, wtype, q})
        acc_reg(1'b1, 6'h0a, 8'hff);
        acc_reg(1'b0, 6'h0a, 8'h00);
        `CHK("display pointer", 8'h1f, q)
        acc_reg(1'b1, 6'h0a, 8'h03);
        acc_reg(1'b1, 6'h0b, 8'ha5);
        acc_reg(1'b0, 6'h0b, 8'h00);
        `CHK("window", 8'h05, q)
        acc_reg(1'b1, 6'h09, 8'h03);
        repeat (3) @(posedge sys_clk);
        `CHK("seg off", 32'h0, seg)
        acc_reg(1'b1, 6'h09, 8'h13);
        repeat (2) begin
            n = 0;
            do begin
                @(posedge sys_clk);
                #1 n++;
            end while (ctick !== 1'b1 && n < 1000);
        end
        `CHK("com period", 232, n)
        repeat (4) @(posedge sys_clk);
        `CHK("seg3", 3'h1, {cidx, seg[3]})
        wrap_up();
    end
endmodule
